// [core/rsb_consts.vh]
// register offsets, field positions and reset values of the status bank
`ifndef RSB_CONSTS_VH
`define RSB_CONSTS_VH
`define RSB_ADDR_GAIN 8'h0e
`define RSB_ADDR_STRENGTH 8'h0f
`define RSB_ADDR_PAGED 8'h10
`define RSB_ADDR_MSEL 8'h11
`define RSB_ADDR_TEST 8'h12
`define RSB_ADDR_VERSION 8'h13
`define RSB_ADDR_IRQ_STATUS 8'h20
`define RSB_ADDR_IRQ_MASK 8'h21
`define RSB_PAGE_LEVEL 3'h0
`define RSB_PAGE_VCO 3'h1
`define RSB_PAGE_CAL 3'h2
`define RSB_PAGE_PILOT 3'h3
`define RSB_PAGE_HI 16
`define RSB_PAGE_LO 14
`define RSB_MSEL_NONE 3'h0
`define RSB_MSEL_MIXER_A 3'h1
`define RSB_MSEL_ADC_PIN 3'h3
`define RSB_MSEL_RF_LEVEL 3'h4
`define RSB_MSEL_SUPPLY 3'h7
`define RSB_RESET_MSEL 8'h00
`define RSB_RESET_TEST 24'h000000
`define RSB_RESET_MASK 8'h00
`define RSB_IRQ_RX_START 0
`define RSB_IRQ_TX_START 1
`define RSB_IRQ_RF_LOST 2
`define RSB_IRQ_PLL_LOST 3
`define RSB_IRQ_OSC_LOST 4
`define RSB_IRQ_BITS 5
`endif

// [core/rsb_sync.v]
// two flip-flop synchroniser for a bus of asynchronous levels
`timescale 1ns/1ns
module rsb_sync #(
  parameter WIDTH = 1
) (
  input wire CLOCK,
  input wire RST_B,
  input wire [WIDTH-1:0] D,
  output reg [WIDTH-1:0] Q
);
  reg [WIDTH-1:0] meta;

  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      meta <= {WIDTH{1'b0}};
      Q <= {WIDTH{1'b0}};
    end else begin
      meta <= D;
      Q <= meta;
    end
  end
endmodule

// [core/rsb_status_bank.v]
// reader front end status register bank with paged status and interrupt
`timescale 1ns/1ns
`include "rsb_consts.vh"
// Summary of operation
// - gain step in bits 6:4, bit 7 zero
// - bit 3 shows decoder input A or B
// - decoder input held from reception until next reception
// - bits 2:0 rf, synth, crystal ready
// - upper strength nibble is Q channel
// - lower strength nibble is I channel
// - strength held from reception until next reception
// - page 0 shows input levels A, B
// - page 1 shows VCO status
// - VCO range bits 7:4, type bit 3
// - VCO pin voltage in bits 2:0
// - page 2 shows filter calibration
// - highpass bits 7:4, lowpass bits 3:0
// - page 3 shows pilot frequency
// - pilot frequency fills all eight bits
// - measurement source select in bits 2:0
module rsb_status_bank #(
  parameter [7:0] VERSION = 8'h5a // arbitrary value
) (
  input wire CLOCK,
  input wire RST_B,
  input wire [7:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  output wire IRQ,
  input wire [2:0] GAIN_STEP,
  input wire DECODER_IN_B,
  input wire RF_LEVEL_STABLE,
  input wire SYNTH_LOCKED,
  input wire OSC_STABLE,
  input wire [3:0] STRENGTH_I,
  input wire [3:0] STRENGTH_Q,
  input wire [2:0] LEVEL_A,
  input wire [2:0] LEVEL_B,
  input wire [3:0] VCO_RANGE_INFO,
  input wire VCO_TYPE_1800,
  input wire [2:0] VCO_PIN_VOLTAGE,
  input wire [3:0] HIGHPASS_CAL_RESULT,
  input wire [3:0] LOWPASS_CAL_RESULT,
  input wire [7:0] PILOT_FREQ,
  input wire RX_ACTIVE,
  input wire TX_ACTIVE,
  output wire [2:0] MEAS_SOURCE,
  output wire [23:0] TEST_SETTING
);
  // ----------------------------------------
  // input synchronisation
  // ----------------------------------------
  localparam SW = 47;
  wire [SW-1:0] raw = {GAIN_STEP, DECODER_IN_B, RF_LEVEL_STABLE,
    SYNTH_LOCKED, OSC_STABLE, STRENGTH_I, STRENGTH_Q, LEVEL_A, LEVEL_B,
    VCO_RANGE_INFO, VCO_TYPE_1800, VCO_PIN_VOLTAGE, HIGHPASS_CAL_RESULT,
    LOWPASS_CAL_RESULT, PILOT_FREQ, RX_ACTIVE, TX_ACTIVE};
  wire [SW-1:0] s;

  rsb_sync #(.WIDTH(SW)) u_sync (
    .CLOCK(CLOCK),
    .RST_B(RST_B),
    .D(raw),
    .Q(s)
  );

  wire [2:0] gain_step = s[46:44];
  wire decoder_in_b = s[43];
  wire rf_level_stable = s[42];
  wire synth_locked = s[41];
  wire osc_stable = s[40];
  wire [3:0] strength_i = s[39:36];
  wire [3:0] strength_q = s[35:32];
  wire [2:0] level_a = s[31:29];
  wire [2:0] level_b = s[28:26];
  wire [3:0] vco_range_info = s[25:22];
  wire vco_type_1800 = s[21];
  wire [2:0] vco_pin_voltage = s[20:18];
  wire [3:0] highpass_cal_result = s[17:14];
  wire [3:0] lowpass_cal_result = s[13:10];
  wire [7:0] pilot_freq = s[9:2];
  wire rx_active = s[1];
  wire tx_active = s[0];

  // one-cycle events from level changes of synchronised inputs
  function went_high;
    input cur;
    input prev;
    begin
      went_high = cur & ~prev;
    end
  endfunction

  function went_low;
    input cur;
    input prev;
    begin
      went_low = ~cur & prev;
    end
  endfunction

  // ----------------------------------------
  // link phase tracking
  // ----------------------------------------
  localparam [3:0] PH_IDLE = 4'b0001;
  localparam [3:0] PH_RECEIVE = 4'b0010;
  localparam [3:0] PH_HOLD = 4'b0100;
  localparam [3:0] PH_SEND = 4'b1000;
  reg [3:0] phase;
  reg [3:0] next_phase;

  // transmission start closes the window of valid reception values
  always @* begin
    next_phase = phase;
    case (phase)
      PH_IDLE: begin
        if (tx_active) begin
          next_phase = PH_SEND;
        end else if (rx_active) begin
          next_phase = PH_RECEIVE;
        end
      end
      PH_RECEIVE: begin
        if (tx_active) begin
          next_phase = PH_SEND;
        end else if (!rx_active) begin
          next_phase = PH_HOLD;
        end
      end
      PH_HOLD: begin
        if (tx_active) begin
          next_phase = PH_SEND;
        end else if (rx_active) begin
          next_phase = PH_RECEIVE;
        end
      end
      PH_SEND: begin
        if (!tx_active) begin
          next_phase = rx_active ? PH_RECEIVE : PH_IDLE;
        end
      end
      default: begin
        next_phase = PH_IDLE;
      end
    endcase
  end

  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      phase <= PH_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  wire capture = next_phase == PH_RECEIVE;

  // ----------------------------------------
  // reception capture
  // ----------------------------------------
  reg rx_prev;
  reg tx_prev;
  reg held_in_b;
  reg [3:0] held_i;
  reg [3:0] held_q;
  wire rx_start = went_high(rx_active, rx_prev);
  wire tx_start = went_high(tx_active, tx_prev);

  // values tracked while receiving, frozen after until next reception
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      rx_prev <= 1'b0;
      tx_prev <= 1'b0;
      held_in_b <= 1'b0;
      held_i <= 4'h0;
      held_q <= 4'h0;
    end else begin
      rx_prev <= rx_active;
      tx_prev <= tx_active;
      if (capture) begin
        held_in_b <= decoder_in_b;
        held_i <= strength_i;
        held_q <= strength_q;
      end
    end
  end

  // ----------------------------------------
  // writable registers
  // ----------------------------------------
  reg [7:0] meas_select;
  reg [23:0] test_setting;
  reg [7:0] irq_mask;

  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      meas_select <= `RSB_RESET_MSEL;
      test_setting <= `RSB_RESET_TEST;
      irq_mask <= `RSB_RESET_MASK;
    end else if (WR) begin
      // read-only offsets fall through untouched
      case (ADDR)
        `RSB_ADDR_MSEL: begin
          meas_select <= {4'h0, WDATA[3:0]};
        end
        `RSB_ADDR_TEST: begin
          test_setting <= {test_setting[15:0], WDATA};
        end
        `RSB_ADDR_IRQ_MASK: begin
          irq_mask <= {3'h0, WDATA[4:0]};
        end
        default: begin
          meas_select <= meas_select;
        end
      endcase
    end
  end

  assign MEAS_SOURCE = meas_select[2:0];
  assign TEST_SETTING = test_setting;

  // ----------------------------------------
  // interrupt status
  // ----------------------------------------
  reg rf_prev;
  reg pll_prev;
  reg osc_prev;
  reg [7:0] irq_status;
  wire [7:0] irq_event;
  wire status_read = RD && (ADDR == `RSB_ADDR_IRQ_STATUS);

  assign irq_event = {3'h0, went_low(osc_stable, osc_prev),
    went_low(synth_locked, pll_prev), went_low(rf_level_stable, rf_prev),
    tx_start, rx_start};

  // set wins over read clear
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      rf_prev <= 1'b0;
      pll_prev <= 1'b0;
      osc_prev <= 1'b0;
      irq_status <= 8'h00;
    end else begin
      rf_prev <= rf_level_stable;
      pll_prev <= synth_locked;
      osc_prev <= osc_stable;
      irq_status <= (status_read ? 8'h00 : irq_status) | irq_event;
    end
  end

  assign IRQ = |(irq_status & irq_mask);

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  wire [2:0] page = test_setting[`RSB_PAGE_HI:`RSB_PAGE_LO];

  function [7:0] paged_value;
    input [2:0] sel;
    begin
      case (sel)
        `RSB_PAGE_LEVEL: begin
          paged_value = {2'h0, level_a, level_b};
        end
        `RSB_PAGE_VCO: begin
          paged_value = {vco_range_info, vco_type_1800, vco_pin_voltage};
        end
        `RSB_PAGE_CAL: begin
          paged_value = {highpass_cal_result, lowpass_cal_result};
        end
        `RSB_PAGE_PILOT: begin
          paged_value = pilot_freq;
        end
        default: begin
          paged_value = 8'h00;
        end
      endcase
    end
  endfunction

  // gain and readiness word, reserved top bit reads zero
  function [7:0] gain_word;
    input [2:0] step;
    input in_b;
    input [2:0] ready;
    begin
      gain_word = {1'b0, step, in_b, ready};
    end
  endfunction

  reg [7:0] next_rdata;

  always @* begin
    next_rdata = 8'h00;
    case (ADDR)
      `RSB_ADDR_GAIN: begin
        next_rdata = gain_word(gain_step, held_in_b,
          {rf_level_stable, synth_locked, osc_stable});
      end
      `RSB_ADDR_STRENGTH: begin
        next_rdata = {held_q, held_i};
      end
      `RSB_ADDR_PAGED: begin
        next_rdata = paged_value(page);
      end
      `RSB_ADDR_MSEL: begin
        next_rdata = meas_select;
      end
      `RSB_ADDR_TEST: begin
        next_rdata = test_setting[7:0];
      end
      `RSB_ADDR_VERSION: begin
        next_rdata = VERSION;
      end
      `RSB_ADDR_IRQ_STATUS: begin
        next_rdata = irq_status;
      end
      `RSB_ADDR_IRQ_MASK: begin
        next_rdata = irq_mask;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      RDATA <= next_rdata;
    end else begin
      RDATA <= 8'h00;
    end
  end
endmodule

// [tb/rsb_props.sv]
// assertion checker of the status bank ports
`timescale 1ns/1ns
module rsb_props #(
  parameter [7:0] VERSION = 8'h5a
) (
  input wire CLOCK,
  input wire RST_B,
  input wire [7:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [7:0] RDATA,
  input wire [2:0] GAIN_STEP,
  input wire RF_LEVEL_STABLE,
  input wire SYNTH_LOCKED,
  input wire OSC_STABLE,
  input wire [2:0] LEVEL_A,
  input wire [2:0] LEVEL_B,
  input wire [7:0] PILOT_FREQ,
  input wire [2:0] MEAS_SOURCE,
  input wire [23:0] TEST_SETTING
);
  // --------------------------------
  // inputs quiet past the synchroniser
  // --------------------------------
  wire [19:0] lv = {GAIN_STEP, RF_LEVEL_STABLE, SYNTH_LOCKED, OSC_STABLE,
    LEVEL_A, LEVEL_B, PILOT_FREQ};
  reg [19:0] q;
  reg [2:0] n;
  wire calm = n == 3'h5 && lv == q;
  wire rdp = RD && ADDR == 8'h10 && calm;
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      q <= 20'h0;
      n <= 3'h0;
    end else begin
      q <= lv;
      n <= lv != q ? 3'h0 : n == 3'h5 ? n : n + 3'h1;
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  gain_field_a:
    assert property (RD && ADDR == 8'h0e && calm |=>
      RDATA[7:4] == {1'b0, q[19:17]}) else $error("gain field wrong");
  ready_bits_a:
    assert property (RD && ADDR == 8'h0e && calm |=>
      RDATA[2:0] == q[16:14]) else $error("ready bits wrong");
  level_page_a:
    assert property (rdp && TEST_SETTING[16:14] == 3'h0 |=>
      RDATA == {2'b00, q[13:8]}) else $error("level page wrong");
  pilot_page_a:
    assert property (rdp && TEST_SETTING[16:14] == 3'h3 |=>
      RDATA == q[7:0]) else $error("pilot page wrong");
  meas_source_a:
    assert property (WR && ADDR == 8'h11 |=>
      {5'h00, MEAS_SOURCE} == ($past(WDATA) & 8'h07))
      else $error("source select wrong");
  test_byte_a:
    assert property (WR && ADDR == 8'h12 |=>
      TEST_SETTING[7:0] == $past(WDATA)) else $error("test byte wrong");
  version_read_a:
    assert property (RD && ADDR == 8'h13 |=> RDATA == VERSION)
      else $error("version wrong");
  ro_write_a:
    assert property (WR && ADDR != 8'h11 && ADDR != 8'h12 |=>
      $stable(MEAS_SOURCE) && $stable(TEST_SETTING))
      else $error("stray write effect");
endmodule
bind rsb_status_bank rsb_props #(.VERSION(VERSION)) rsb_props_inst (.*);

// [tb/testbench.sv]
// self-checking bench of the status bank
`timescale 1ns/1ns
module testbench;
  localparam [7:0] VER = 8'h3c; // arbitrary value
  localparam [14:0] codes = {3'h7, 3'h4, 3'h3, 3'h1, 3'h0};
  localparam [31:0] ro = {8'h13, 8'h10, 8'h0f, 8'h0e};
  reg CLOCK, RST_B, WR, RD, RX, TX;
  reg [7:0] ADDR, WDATA, d;
  reg [44:0] an, h;
  reg [63:0] r;
  integer seed, fails, comparisons, i, p;
  wire [7:0] RDATA;
  wire IRQ;
  wire [2:0] MEAS_SOURCE;
  wire [23:0] TEST_SETTING;
  rsb_status_bank #(.VERSION(VER)) rsb_status_bank_inst (.CLOCK(CLOCK),
    .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .IRQ(IRQ), .GAIN_STEP(an[2:0]), .DECODER_IN_B(an[3]),
    .RF_LEVEL_STABLE(an[4]), .SYNTH_LOCKED(an[5]), .OSC_STABLE(an[6]),
    .STRENGTH_I(an[10:7]), .STRENGTH_Q(an[14:11]), .LEVEL_A(an[17:15]),
    .LEVEL_B(an[20:18]), .VCO_RANGE_INFO(an[24:21]),
    .VCO_TYPE_1800(an[25]), .VCO_PIN_VOLTAGE(an[28:26]),
    .HIGHPASS_CAL_RESULT(an[32:29]), .LOWPASS_CAL_RESULT(an[36:33]),
    .PILOT_FREQ(an[44:37]), .RX_ACTIVE(RX), .TX_ACTIVE(TX),
    .MEAS_SOURCE(MEAS_SOURCE), .TEST_SETTING(TEST_SETTING));
  // ------------------
  // expected read data
  // ------------------
  function [7:0] ev(input [7:0] a, input [2:0] g, input [44:0] v, k);
    begin
      ev = 8'h00;
      if (a == 8'h0e) ev = {1'b0, v[2:0], k[3], v[4], v[5], v[6]};
      if (a == 8'h0f) ev = k[14:7];
      if (a == 8'h13) ev = VER;
      if (a == 8'h10 && g == 3'h0) ev = {2'b00, v[17:15], v[20:18]};
      if (a == 8'h10 && g == 3'h1) ev = {v[24:21], v[25], v[28:26]};
      if (a == 8'h10 && g == 3'h2) ev = {v[32:29], v[36:33]};
      if (a == 8'h10 && g == 3'h3) ev = v[44:37];
    end
  endfunction
  task check(input [23:0] seen, input [23:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge CLOCK);
      ADDR <= a;
      WDATA <= v;
      WR <= 1'b1;
      @(posedge CLOCK);
      WR <= 1'b0;
      #1;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge CLOCK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLOCK);
      RD <= 1'b0;
      #1;
      check(RDATA, e);
    end
  endtask
  // two-stage synchroniser latency plus margin
  task settle;
    begin
      repeat (6) @(posedge CLOCK);
      #1;
    end
  endtask
  task conclude;
    begin
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  initial begin
    repeat (100000) @(posedge CLOCK);
    fails = fails + 1;
    conclude;
  end
  initial begin
    seed = 32'h12685c90;
    fails = 0;
    comparisons = 0;
    {RST_B, WR, RD, RX, TX, ADDR, WDATA, an, h} = 0;
    repeat (16) @(posedge CLOCK);
    RST_B <= 1'b1;
    wr(8'h21, 8'h01);
    @(posedge CLOCK);
    RX <= 1'b1;
    settle;
    check(IRQ, 1'b1);
    rd(8'h20, 8'h01);
    check(IRQ, 1'b0);
    @(posedge CLOCK);
    TX <= 1'b1;
    settle;
    check(IRQ, 1'b0);
    @(posedge CLOCK);
    TX <= 1'b0;
    rd(8'h20, 8'h02);
    for (i = 0; i < 25; i = i + 1) begin
      r = i < 2 ? {64{i[0]}} : {$random(seed), $random(seed)};
      @(posedge CLOCK);
      an <= r[44:0];
      p = i % 5;
      wr(8'h12, {7'h00, p[2]});
      wr(8'h12, {p[1:0], r[50:45]});
      wr(8'h12, r[58:51]);
      settle;
      check(TEST_SETTING, {7'h00, p[2:0], r[50:45], r[58:51]});
      rd(8'h0e, ev(8'h0e, 3'h0, an, an));
      rd(8'h0f, ev(8'h0f, 3'h0, an, an));
      rd(8'h10, ev(8'h10, p[2:0], an, an));
    end
    h = an;
    @(posedge CLOCK);
    RX <= 1'b0;
    settle;
    @(posedge CLOCK);
    an <= ~an;
    settle;
    rd(8'h0f, ev(8'h0f, 3'h0, an, h));
    rd(8'h0e, ev(8'h0e, 3'h0, an, h));
    for (i = 0; i < 5; i = i + 1) begin
      r = {$random(seed), $random(seed)};
      d = {r[4:0], codes[3*i +: 3]};
      wr(8'h11, d);
      check(MEAS_SOURCE, codes[3*i +: 3]);
      rd(8'h11, {4'h0, d[3:0]});
    end
    for (i = 0; i < 4; i = i + 1) begin
      d = ro[8*i +: 8];
      wr(d, r[7:0]);
      rd(d, ev(d, p[2:0], an, h));
    end
    rd(8'h7f, 8'h00);
    conclude;
  end
endmodule
